// File: rtl/ttsc_pkg.sv
// Package: constants and types of the trigger, terminator and status command block
package ttsc_pkg;
    // ==========================================
    // Register offsets and fields
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_RESP = 4'h4;
    localparam logic [3:0] ADDR_STATE = 4'h8;
    localparam logic [3:0] ADDR_PORT = 4'hC;
    localparam int RESP_VALID_BIT = 8;
    localparam int RESP_LAST_BIT = 9;
    localparam int RESP_KIND_LSB = 10;
    localparam int ST_RUN_BIT = 3;
    localparam int ST_TEST_BIT = 4;
    localparam int ST_PREF_LSB = 5;
    localparam int ST_PROG_LSB = 8;
    localparam int ST_PTR_LSB = 10;
    localparam int ST_TERM_LSB = 24;
    localparam int PORT_IN_LSB = 4;
    // ==========================================
    // Characters
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_Y = 8'h59;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_U = 8'h55;
    localparam logic [7:0] CH_J = 8'h4A;
    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_I = 8'h49;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_Z = 8'h5A;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_SLASH = 8'h2F;
    localparam logic [7:0] CH_E_LO = 8'h65;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_DEL = 8'h7F;
    localparam logic [7:0] FIELD_AND = 8'h0F;
    localparam logic [7:0] FIELD_OR = 8'h30;
    // ==========================================
    // Option limits and defaults
    localparam logic [6:0] MAX_TRIG = 7'h07;
    localparam logic [6:0] MAX_PROG = 7'h02;
    localparam logic [6:0] MAX_PREF = 7'h05;
    localparam logic [6:0] MAX_UREQ = 7'h01;
    localparam logic [6:0] MAX_TEST = 7'h00;
    localparam logic [6:0] MAX_MASK = 7'h63;
    localparam logic [6:0] TEN = 7'h0A;
    localparam logic [1:0] MAX_DIGITS = 2'h2;
    localparam logic [2:0] TRIG_DEFAULT = 3'h6;
    localparam logic [1:0] PROG_SINGLE = 2'h0;
    localparam logic [1:0] PROG_STEP = 2'h2;
    localparam logic [6:0] PTR_FIRST = 7'h01;
    localparam logic [6:0] PTR_LAST = 7'h64;
    localparam int RESP_DEPTH = 18;
    localparam logic [4:0] RESP_ONE = 5'h01;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        TTSC_REQ_NONE,
        TTSC_REQ_FULL,
        TTSC_REQ_PORT
    } ttsc_req_t;
    typedef struct packed {
        logic [2:0] trig;
        logic [1:0] prog;
        logic [2:0] pref;
        logic [6:0] mask;
        logic [7:0] term_first;
        logic [7:0] term_last;
        logic [1:0] term_cnt;
    } ttsc_cfg_t;
    localparam ttsc_cfg_t CFG_DEFAULT = '{
        trig: TRIG_DEFAULT, prog: PROG_STEP, pref: 3'h0, mask: 7'h00,
        term_first: CH_CR, term_last: CH_LF, term_cnt: 2'h2};
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } ttsc_avs_req_t;
    typedef struct packed {
        logic talk;
        logic get;
        logic ext;
        logic clear;
    } ttsc_evt_t;
    typedef struct packed {
        logic [3:0] d;
        logic [3:0] f;
        logic [3:0] k;
        logic [3:0] r;
    } ttsc_modes_t;
endpackage

// File: rtl/ttsc_top.sv
// Trigger mode, programmable terminator and status word command block
// Contract
// RULE1: Options 0-7; even start, odd stop
// RULE2: Trigger option 6 after reset or clear
// RULE3: Stimulus: talk, GET, execute, external pulse
// RULE4: Stimulus acts only in armed direction
// RULE5: Start resumes at next higher location
// RULE6: Step mode: one location per trigger
// RULE7: Stop trigger halts program at once
// RULE8: Terminator CR LF after reset or clear
// RULE9: Terminator char follows letter; some forbidden
// RULE10: LF gives CR LF, CR gives LF CR, DEL none
// RULE11: Full status: prefix then mode bytes
// RULE12: Port status: two decimals with comma
// RULE13: One status answer per request
// RULE14: Mask field carries programmed mask value
// RULE15: Port prefix only in even prefix settings
// RULE16: Model prefix only in even prefix settings
// RULE17: Terminator field masked then ORed
// RULE18: Self-test flag set, cleared when read
// RULE19: Port value bit 3 most significant
// RULE20: Controller reads status right after request
// RULE21: Missing parameter means option zero
// RULE22: Bad option flags error, drops string
// RULE23: Forbidden terminator rejected, old kept
`timescale 1ns/1ps
`default_nettype none
module ttsc_top #(
    // Model number bytes, value arbitrary
    parameter logic [23:0] MODEL_ID = 24'h31_3030
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Avalon-MM slave
    input wire ttsc_pkg::ttsc_avs_req_t avs_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Bus events and other mode digits
    input wire ttsc_pkg::ttsc_evt_t evt_in,
    input wire ttsc_pkg::ttsc_modes_t modes_in,
    input wire logic step_done_in,
    // Digital port
    input wire logic [3:0] port_in,
    output logic [3:0] port_out,
    // Program execution
    output logic running_out,
    output logic [6:0] mem_ptr_out,
    output logic invalid_option_error_out
);
    import ttsc_pkg::*;

    typedef enum logic [1:0] {
        TTSC_PS_LETTER,
        TTSC_PS_PARAM,
        TTSC_PS_TERM
    } ttsc_ps_t;

    // ==========================================
    // Helpers
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= CH_0) && (c <= CH_9);
    endfunction

    function automatic logic is_upper(input logic [7:0] c);
        return (c >= CH_A) && (c <= CH_Z);
    endfunction

    function automatic logic bad_term(input logic [7:0] c);
        return is_digit(c) || is_upper(c) || c == CH_SP || c == CH_PLUS
            || c == CH_SLASH || c == CH_COMMA || c == CH_DOT || c == CH_E_LO;
    endfunction

    function automatic logic [7:0] dec_hi(input logic [6:0] v);
        return CH_0 + {1'b0, 7'(v / TEN)};
    endfunction

    function automatic logic [7:0] dec_lo(input logic [6:0] v);
        return CH_0 + {1'b0, 7'(v % TEN)};
    endfunction

    function automatic logic [7:0] nib(input logic [3:0] v);
        return CH_0 + {4'h0, v};
    endfunction

    function automatic logic [6:0] ptr_inc(input logic [6:0] p);
        return (p == PTR_LAST) ? PTR_FIRST : 7'(p + PTR_FIRST);
    endfunction

    // ==========================================
    // Reset release
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ==========================================
    // Avalon-MM slave, one wait state
    logic ack_q;
    logic req;
    logic acc_wr;
    logic acc_rd;
    logic [31:0] rd_mux;

    assign req = avs_in.read | avs_in.write;
    assign avs_waitrequest_out = req & ~ack_q;
    assign acc_wr = avs_in.write & ack_q;
    assign acc_rd = avs_in.read & ack_q;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_in.read & ~ack_q) begin
            avs_readdata_out <= rd_mux;
        end
    end

    // ==========================================
    // Command parser
    ttsc_ps_t ps, next_ps;
    logic [7:0] letter, next_letter;
    logic [6:0] val, next_val;
    logic [1:0] ndig, next_ndig;
    ttsc_cfg_t cfg, stg, next_stg;
    logic stg_err, next_err;
    logic stg_test, next_test;
    ttsc_req_t stg_req, next_req;
    logic commit;
    logic x_seen;
    logic char_v;
    logic [7:0] ch;

    assign char_v = acc_wr && avs_in.address == ADDR_CMD && avs_in.byteenable[0];
    assign ch = avs_in.writedata[7:0];

    always_comb begin
        next_ps = ps;
        next_letter = letter;
        next_val = val;
        next_ndig = ndig;
        next_stg = stg;
        next_err = stg_err;
        next_test = stg_test;
        next_req = stg_req;
        commit = 1'b0;
        x_seen = 1'b0;
        if (char_v) begin
            if (ps == TTSC_PS_TERM) begin
                next_ps = TTSC_PS_LETTER;
                if (bad_term(ch)) begin
                    next_err = 1'b1; // see RULE9 see RULE23
                end else if (ch == CH_LF) begin
                    next_stg.term_first = CH_CR; // see RULE10
                    next_stg.term_last = CH_LF;
                    next_stg.term_cnt = 2'h2;
                end else if (ch == CH_CR) begin
                    next_stg.term_first = CH_LF; // see RULE10
                    next_stg.term_last = CH_CR;
                    next_stg.term_cnt = 2'h2;
                end else if (ch == CH_DEL) begin
                    next_stg.term_first = CH_DEL; // see RULE10
                    next_stg.term_last = CH_DEL;
                    next_stg.term_cnt = 2'h0;
                end else begin
                    next_stg.term_first = ch; // see RULE9
                    next_stg.term_last = ch;
                    next_stg.term_cnt = 2'h1;
                end
            end else if (ch == CH_SP) begin
                next_ps = ps;
            end else if (ps == TTSC_PS_PARAM && is_digit(ch)) begin
                if (ndig == MAX_DIGITS) begin
                    next_err = 1'b1;
                end else begin
                    next_val = 7'(val * TEN) + {3'h0, ch[3:0]};
                    next_ndig = 2'(ndig + 2'h1);
                end
            end else begin
                // Close the pending letter; no digits leaves zero
                if (ps == TTSC_PS_PARAM) begin // see RULE21
                    case (letter)
                        CH_T: begin
                            if (val > MAX_TRIG) next_err = 1'b1; // see RULE1 see RULE22
                            else next_stg.trig = val[2:0];
                        end
                        CH_P: begin
                            if (val > MAX_PROG) next_err = 1'b1; // see RULE22
                            else next_stg.prog = val[1:0];
                        end
                        CH_G: begin
                            if (val > MAX_PREF) next_err = 1'b1; // see RULE22
                            else next_stg.pref = val[2:0];
                        end
                        CH_M: begin
                            if (val > MAX_MASK) next_err = 1'b1; // see RULE22
                            else next_stg.mask = val;
                        end
                        CH_U: begin
                            if (val > MAX_UREQ) next_err = 1'b1; // see RULE22
                            else if (val[0]) next_req = TTSC_REQ_PORT;
                            else next_req = TTSC_REQ_FULL;
                        end
                        CH_J: begin
                            if (val > MAX_TEST) next_err = 1'b1; // see RULE22
                            else next_test = 1'b1;
                        end
                        default: next_err = next_err;
                    endcase
                end
                next_ps = TTSC_PS_LETTER;
                if (ch == CH_X) begin
                    x_seen = 1'b1;
                    commit = 1'b1;
                end else if (ch == CH_Y) begin
                    next_ps = TTSC_PS_TERM;
                end else if (is_upper(ch)) begin
                    next_letter = ch;
                    next_val = 7'h00;
                    next_ndig = 2'h0;
                    next_ps = TTSC_PS_PARAM;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ps <= TTSC_PS_LETTER;
            letter <= 8'h00;
            val <= 7'h00;
            ndig <= 2'h0;
            stg <= CFG_DEFAULT;
            stg_err <= 1'b0;
            stg_test <= 1'b0;
            stg_req <= TTSC_REQ_NONE;
        end else if (evt_in.clear) begin
            ps <= TTSC_PS_LETTER;
            stg <= CFG_DEFAULT;
            stg_err <= 1'b0;
            stg_test <= 1'b0;
            stg_req <= TTSC_REQ_NONE;
        end else begin
            ps <= next_ps;
            letter <= next_letter;
            val <= next_val;
            ndig <= next_ndig;
            if (commit) begin
                // Whole string dropped on error
                stg <= next_err ? cfg : next_stg; // see RULE22
                stg_err <= 1'b0;
                stg_test <= 1'b0;
                stg_req <= TTSC_REQ_NONE;
            end else begin
                stg <= next_stg;
                stg_err <= next_err;
                stg_test <= next_test;
                stg_req <= next_req;
            end
        end
    end

    // ==========================================
    // Committed settings
    logic ok_commit;

    assign ok_commit = commit & ~next_err;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_DEFAULT; // see RULE2 see RULE8
        end else if (evt_in.clear) begin
            cfg <= CFG_DEFAULT; // see RULE2 see RULE8
        end else if (ok_commit) begin
            cfg <= next_stg;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            invalid_option_error_out <= 1'b0;
        end else begin
            invalid_option_error_out <= commit & next_err; // see RULE22
        end
    end

    // ==========================================
    // Trigger and program execution
    logic trig_hit;
    logic trig_start;

    always_comb begin
        case (cfg.trig[2:1])
            2'h0: trig_hit = evt_in.talk; // see RULE3
            2'h1: trig_hit = evt_in.get;
            2'h2: trig_hit = x_seen;
            default: trig_hit = evt_in.ext;
        endcase
    end

    assign trig_start = ~cfg.trig[0]; // see RULE1

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            running_out <= 1'b0;
            mem_ptr_out <= PTR_FIRST;
        end else if (evt_in.clear) begin
            running_out <= 1'b0;
        end else if (trig_hit) begin
            if (cfg.prog == PROG_STEP) begin
                mem_ptr_out <= ptr_inc(mem_ptr_out); // see RULE6
            end else if (trig_start) begin
                running_out <= 1'b1; // see RULE4
                mem_ptr_out <= ptr_inc(mem_ptr_out); // see RULE5
            end else begin
                running_out <= 1'b0; // see RULE4 see RULE7
            end
        end else if (running_out && step_done_in) begin
            if (cfg.prog == PROG_SINGLE && mem_ptr_out == PTR_LAST) begin
                running_out <= 1'b0;
            end else begin
                mem_ptr_out <= ptr_inc(mem_ptr_out);
            end
        end
    end

    // ==========================================
    // Status request and self-test flag
    ttsc_req_t pend;
    logic self_test;
    logic talk_load;

    assign talk_load = evt_in.talk;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pend <= TTSC_REQ_NONE;
        end else if (ok_commit && next_req != TTSC_REQ_NONE) begin
            pend <= next_req;
        end else if (talk_load || evt_in.clear) begin
            pend <= TTSC_REQ_NONE; // see RULE13
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            self_test <= 1'b1; // see RULE18
        end else if (ok_commit && next_test) begin
            self_test <= 1'b1; // see RULE18
        end else if (talk_load && pend == TTSC_REQ_FULL) begin
            self_test <= 1'b0; // see RULE18
        end
    end

    // ==========================================
    // Response builder
    logic [7:0] bld [RESP_DEPTH];
    logic [4:0] k;

    always_comb begin
        for (int i = 0; i < RESP_DEPTH; i++) begin
            bld[i] = 8'h00;
        end
        k = 5'h00;
        if (pend == TTSC_REQ_FULL) begin
            if (!cfg.pref[0]) begin
                bld[0] = MODEL_ID[23:16]; // see RULE16
                bld[1] = MODEL_ID[15:8];
                bld[2] = MODEL_ID[7:0];
                k = 5'h03;
            end
            bld[k] = nib(modes_in.d); // see RULE11
            bld[k + 5'h01] = nib(modes_in.f);
            bld[k + 5'h02] = nib({1'b0, cfg.pref});
            bld[k + 5'h03] = nib({3'h0, self_test});
            bld[k + 5'h04] = nib(modes_in.k);
            bld[k + 5'h05] = nib({2'h0, cfg.prog});
            bld[k + 5'h06] = nib(modes_in.r);
            bld[k + 5'h07] = nib({1'b0, cfg.trig});
            bld[k + 5'h08] = dec_hi(cfg.mask); // see RULE14
            bld[k + 5'h09] = dec_lo(cfg.mask);
            bld[k + 5'h0A] = (cfg.term_last & FIELD_AND) | FIELD_OR; // see RULE17
            k = 5'(k + 5'h0B);
        end else if (pend == TTSC_REQ_PORT) begin
            if (!cfg.pref[0]) begin
                bld[0] = CH_I; // see RULE15
                bld[1] = CH_SLASH;
                bld[2] = CH_O;
                k = 5'h03;
            end
            bld[k] = dec_hi({3'h0, port_in}); // see RULE12 see RULE19
            bld[k + 5'h01] = dec_lo({3'h0, port_in});
            bld[k + 5'h02] = CH_COMMA;
            bld[k + 5'h03] = dec_hi({3'h0, port_out}); // see RULE19
            bld[k + 5'h04] = dec_lo({3'h0, port_out});
            k = 5'(k + 5'h05);
        end
        if (cfg.term_cnt == 2'h2) begin
            bld[k] = cfg.term_first;
            k = 5'(k + RESP_ONE);
        end
        if (cfg.term_cnt != 2'h0) begin
            bld[k] = cfg.term_last; // see RULE10
            k = 5'(k + RESP_ONE);
        end
    end

    // ==========================================
    // Response buffer, popped by reads
    logic [7:0] resp [RESP_DEPTH];
    logic [4:0] resp_len;
    logic [4:0] resp_idx;
    ttsc_req_t resp_kind;
    logic resp_valid;
    logic pop;

    assign resp_valid = resp_idx < resp_len;
    assign pop = acc_rd && avs_in.address == ADDR_RESP && resp_valid;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < RESP_DEPTH; i++) begin
                resp[i] <= 8'h00;
            end
            resp_len <= 5'h00;
            resp_idx <= 5'h00;
            resp_kind <= TTSC_REQ_NONE;
        end else if (talk_load) begin
            resp <= bld; // see RULE11 see RULE13
            resp_len <= k;
            resp_idx <= 5'h00;
            resp_kind <= pend;
        end else if (pop) begin
            resp_idx <= 5'(resp_idx + RESP_ONE);
        end
    end

    // ==========================================
    // Port output register
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            port_out <= 4'h0;
        end else if (acc_wr && avs_in.address == ADDR_PORT && avs_in.byteenable[0]) begin
            port_out <= avs_in.writedata[3:0];
        end
    end

    // ==========================================
    // Read data decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_in.address == ADDR_RESP) begin
            if (resp_valid) begin
                rd_mux[7:0] = resp[resp_idx];
            end
            rd_mux[RESP_VALID_BIT] = resp_valid;
            rd_mux[RESP_LAST_BIT] = resp_valid && (5'(resp_idx + RESP_ONE) == resp_len);
            rd_mux[RESP_KIND_LSB +: 2] = resp_kind;
        end else if (avs_in.address == ADDR_STATE) begin
            rd_mux[2:0] = cfg.trig;
            rd_mux[ST_RUN_BIT] = running_out;
            rd_mux[ST_TEST_BIT] = self_test;
            rd_mux[ST_PREF_LSB +: 3] = cfg.pref;
            rd_mux[ST_PROG_LSB +: 2] = cfg.prog;
            rd_mux[ST_PTR_LSB +: 7] = mem_ptr_out;
            rd_mux[ST_TERM_LSB +: 8] = cfg.term_last;
        end else if (avs_in.address == ADDR_PORT) begin
            rd_mux[3:0] = port_out;
            rd_mux[PORT_IN_LSB +: 4] = port_in;
        end
    end

endmodule
`default_nettype wire

// File: testbench/ttsc_properties.sv
// Assertion checker of the trigger, terminator and status command block
`timescale 1ns/1ps
`default_nettype none
module ttsc_properties (
    // Watched ports
    input wire logic mclk_in, input wire logic rst_n_in,
    input wire ttsc_pkg::ttsc_avs_req_t avs_in, input wire logic avs_waitrequest_out,
    input wire ttsc_pkg::ttsc_evt_t evt_in, input wire logic [3:0] port_out,
    input wire logic running_out, input wire logic [6:0] mem_ptr_out,
    input wire logic invalid_option_error_out
);
    import ttsc_pkg::*;
    logic acc;
    logic x_acc;
    logic [1:0] x_hist;
    assign acc = avs_in.write & ~avs_waitrequest_out;
    assign x_acc = acc && avs_in.address == ADDR_CMD && avs_in.writedata[7:0] == CH_X;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            x_hist <= 2'h0;
        end else begin
            x_hist <= {x_hist[0], x_acc};
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_quiet;
        !running_out && evt_in == '0 && !avs_in.write;
    endsequence
    a_err_once: assert property (invalid_option_error_out |=> !invalid_option_error_out)
        else $error("error pulse too long");
    a_err_cause: assert property (invalid_option_error_out |-> |x_hist)
        else $error("error without string end");
    a_ptr_step: assert property ($changed(mem_ptr_out) |-> mem_ptr_out ==
        (($past(mem_ptr_out) == PTR_LAST) ? PTR_FIRST : $past(mem_ptr_out) + 7'h01))
        else $error("pointer jump");
    a_ptr_range: assert property (mem_ptr_out >= PTR_FIRST && mem_ptr_out <= PTR_LAST)
        else $error("pointer out of range");
    a_start_adv: assert property ($rose(running_out) |-> $changed(mem_ptr_out))
        else $error("start without advance");
    a_idle_hold: assert property (s_quiet [*4] |=> $stable(mem_ptr_out))
        else $error("pointer moved while halted");
    a_port_load: assert property (acc && avs_in.address == ADDR_PORT
        && avs_in.byteenable[0] |=> port_out == $past(avs_in.writedata[3:0]))
        else $error("port lines wrong");
    a_wait_one: assert property (avs_in.read && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("read not answered");
endmodule
bind ttsc_top ttsc_properties u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_in(avs_in), .evt_in(evt_in),
    .avs_waitrequest_out(avs_waitrequest_out), .port_out(port_out), .running_out(running_out),
    .mem_ptr_out(mem_ptr_out), .invalid_option_error_out(invalid_option_error_out)
);
`default_nettype wire

// File: testbench/ttsc_ctrl_model.sv
// Bus controller model issuing talk, trigger and clear events
`timescale 1ns/1ps
`default_nettype none
module ttsc_ctrl_model (
    // Clock and events
    input wire logic clk_in,
    output var ttsc_pkg::ttsc_evt_t evt_out
);
    import ttsc_pkg::*;
    initial evt_out = '0;
    task send(input ttsc_evt_t e);
        @(posedge clk_in);
        evt_out <= e;
        @(posedge clk_in);
        evt_out <= '0;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the trigger, terminator and status command block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ttsc_pkg::*;
    logic mclk_in = 0, rst_n_in = 0, err_seen = 0, wreq, run, err;
    ttsc_avs_req_t avs = '0;
    ttsc_evt_t evt;
    logic [31:0] rdata, v;
    logic [3:0] pout;
    logic [6:0] ptr, p;
    logic step_done = 0;
    logic [3:0] pin = 4'hA;
    ttsc_modes_t modes = 16'h1234;
    int error_cnt = 0, checked = 0;
    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (err === 1'b1) err_seen <= 1'b1;
    ttsc_ctrl_model u_ctrl (.clk_in(mclk_in), .evt_out(evt));
    // Model bytes arbitrary
    ttsc_top #(.MODEL_ID(24'h39_3939)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .avs_in(avs), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .evt_in(evt),
        .modes_in(modes), .step_done_in(step_done), .port_in(pin), .port_out(pout),
        .running_out(run), .mem_ptr_out(ptr), .invalid_option_error_out(err));
    task final_report;
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        avs <= '{r, !r, a, 4'hF, d};
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) begin
            error_cnt++;
            final_report();
        end
        v = rdata;
        avs <= '0;
    endtask
    task cmd(input string s);
        foreach (s[i]) bus(0, ADDR_CMD, {24'h0, s[i]});
    endtask
    task settle;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task resp(input logic [127:0] e, input int n, input logic [1:0] k);
        u_ctrl.send(4'h8);
        settle();
        for (int i = 0; i <= n; i++) begin
            bus(1, ADDR_RESP, 0);
            chk("byte", v[7:0], (i < n) ? e[8*(n-1-i)+:8] : 8'h00);
            chk("kind", v[11:10], k);
            chk("flags", v[9:8], {i == n - 1, i < n});
        end
    endtask
    task t_status;
        bus(1, ADDR_STATE, 0);
        chk("test", v[ST_TEST_BIT], 1);
        cmd("M42U0X");
        resp({"9991201324642:", CH_CR, CH_LF}, 16, 1);
        resp({CH_CR, CH_LF}, 2, 0);
        bus(1, ADDR_STATE, 0);
        chk("test", v[ST_TEST_BIT], 0);
        cmd("G1JU0X");
        resp({"1211324642:", CH_CR, CH_LF}, 13, 1);
    endtask
    task t_port;
        bus(0, ADDR_PORT, 5);
        cmd("U1X");
        chk("port", pout, 5);
        resp({"10,05", CH_CR, CH_LF}, 7, 2);
        pin <= 4'h3;
        cmd("G0U1X");
        resp({"I/O03,05", CH_CR, CH_LF}, 10, 2);
    endtask
    task t_bad;
        err_seen = 0;
        cmd("T3T9X");
        settle();
        chk("error", err_seen, 1);
        bus(1, ADDR_STATE, 0);
        chk("trig", v[2:0], 6);
    endtask
    task t_trig;
        p = ptr;
        u_ctrl.send(4'h2);
        settle();
        chk("step", ptr, p + 7'h01);
        for (int t = 0; t < 8; t++) begin
            cmd(string'({"P1T", 8'h30 + t[7:0], "X"}));
            if (t < 6) u_ctrl.send(4'h2);
            settle();
            chk("wrong", run, t[0]);
            if (t / 2 == 2) cmd("X");
            else u_ctrl.send(4'h8 >> (t / 2 - (t > 5)));
            settle();
            chk("run", run, !t[0]);
        end
        cmd("TX");
        bus(1, ADDR_STATE, 0);
        chk("trig", v[2:0], 0);
    endtask
    task t_term;
        cmd("Y\015X");
        resp({CH_LF, CH_CR}, 2, 0);
        p = ptr;
        step_done <= 1;
        @(posedge mclk_in);
        step_done <= 0;
        settle();
        chk("dwell", ptr, p + 7'h01);
        err_seen = 0;
        cmd("YAX");
        settle();
        chk("error", err_seen, 1);
        resp({CH_LF, CH_CR}, 2, 0);
        cmd("Y\177X");
        resp(0, 0, 0);
        u_ctrl.send(4'h1);
        settle();
        bus(1, ADDR_STATE, 0);
        chk("term", v[31:24], CH_LF);
        chk("trig", v[2:0], 6);
    endtask
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        t_status();
        t_port();
        t_bad();
        t_trig();
        t_term();
        final_report();
    end
endmodule
`default_nettype wire
